// [pkg/sixp_regs.vh]
// register map and constants of the six-bit serial-muxed port
`ifndef SIXP_REGS_VH
`define SIXP_REGS_VH
`define SIXP_OFF_DIR      12'h000
`define SIXP_OFF_DATA     12'h004
`define SIXP_OFF_SERIAL   12'h008
`define SIXP_OFF_STBY     12'h00c
`define SIXP_RESET_VAL    8'hc0
`define SIXP_FIXED_MASK   8'hc0
`define SIXP_PIN_MASK     8'h3f
`define SIXP_DIR_READ     8'hff
`define SIXP_PIN_COUNT    6
`define SIXP_B_CLOCK_ENABLE_LOW_0     0
`define SIXP_B_CLOCK_ENABLE_HIGH_0     1
`define SIXP_B_SYNC_0     2
`define SIXP_B_RE_0       3
`define SIXP_B_TE_0       4
`define SIXP_B_SMART_CARD_IFACE_SELECT       5
`define SIXP_B_CLOCK_ENABLE_LOW_1     8
`define SIXP_B_CLOCK_ENABLE_HIGH_1     9
`define SIXP_B_SYNC_1     10
`define SIXP_B_RE_1       11
`define SIXP_B_TE_1       12
`define SIXP_SERIAL_MASK  13'h1f3f
`define SIXP_B_HW_STBY    0
`define SIXP_B_SW_STBY    1
`endif

// [verilog/sixp_pin_cell.v]
// one port pin: function select, drive enable and input sync
`timescale 1ns/1ps
`default_nettype none
module sixp_pin_cell (
  input  wire clk_in,
  input  wire resetn_in,
  input  wire pin_in,
  input  wire latch_in,
  input  wire dir_in,
  input  wire periph_sel_in,
  input  wire periph_out_in,
  input  wire periph_oe_in,
  output wire pin_out,
  output wire pin_oe_n_out,
  output wire level_out
);
  reg sync1_reg;
  reg sync2_reg;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // peripheral owns the pin when selected; otherwise plain port [RULE16]
  assign pin_out      = periph_sel_in ? periph_out_in : latch_in;
  assign pin_oe_n_out = periph_sel_in ? ~periph_oe_in : ~dir_in;
  assign level_out    = sync2_reg;
endmodule
`default_nettype wire

// [verilog/sixp_port.v]
// six-bit general purpose port with serial channel pin sharing, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "sixp_regs.vh"
//
// Contract
// [RULE1] eight-bit data latch, low six bits read/write, drive the pins
// [RULE2] direction one: port read returns the latch bit
// [RULE3] direction zero: port read returns the synchronised pin level
// [RULE4] bits seven and six ignore writes and read as one
// [RULE5] data latch is c0 after reset and during hardware standby
// [RULE6] software standby leaves the data latch unchanged
// [RULE7] pins shared with serial tx, rx, clock and two interrupt inputs
// [RULE8] pin five: channel one clock-enable-high makes it clock input
// [RULE9] pin five: sync select or clock-enable-low makes clock output
// [RULE10] pin four: same clock selection using channel zero bits
// [RULE11] pin three: channel one receive enable makes it receive input
// [RULE12] pin two: smart-card select or receive enable makes receive input
// [RULE13] pin one: channel one transmit enable drives transmit data
// [RULE14] pin zero: smart-card select or transmit enable drives transmit
// [RULE15] smart-card transmit alternates between driving and high impedance
// [RULE16] plain mode: direction one outputs latch, zero is input
// [RULE17] direction register write-only, reads ones, c0 after reset and during hardware standby
// [RULE18] outputs keep driving through software standby
module sixp_port #(
  parameter PIN_COUNT = `SIXP_PIN_COUNT
) (
  input  wire        CLK_SYS_IN,
  input  wire        RESETN_IN,
  input  wire [11:0] PADDR_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [31:0] PWDATA_IN,
  input  wire [3:0]  PSTRB_IN,
  output wire [31:0] PRDATA_OUT,
  output wire        PREADY_OUT,
  output wire        PSLVERR_OUT,
  input  wire [5:0]  PIN_IN,
  output wire [5:0]  PIN_OUT,
  output wire [5:0]  PIN_OE_N_OUT,
  input  wire        TXD0_IN,
  input  wire        TXD0_DRIVE_IN,
  input  wire        TXD1_IN,
  input  wire        SCLK0_IN,
  input  wire        SCLK1_IN,
  output wire        RXD0_OUT,
  output wire        RXD1_OUT,
  output wire        SCLK0_OUT,
  output wire        SCLK1_OUT,
  output wire        EXT_INTERRUPT_FOUR_N_OUT,
  output wire        EXT_INTERRUPT_FIVE_N_OUT,
  output wire [12:0] SERIAL_CTRL_OUT
);
  reg  [7:0]  data_reg;
  reg  [7:0]  dir_reg;
  reg  [12:0] serial_reg;
  reg  [1:0]  stby_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg         slverr_reg;
  reg         addr_ok;
  wire [5:0]  level;
  reg  [5:0]  psel_fn;
  reg  [5:0]  pout_fn;
  reg  [5:0]  poe_fn;
  wire [5:0]  port_read;
  wire        hw_stby;
  wire        setup;
  wire        wr_en;
  wire        sync0;
  wire        sync1;
  wire        clk0_in_sel;
  wire        clk1_in_sel;

  assign hw_stby = stby_reg[`SIXP_B_HW_STBY];
  assign setup   = PSEL_IN & ~PENABLE_IN;
  // single-cycle access: pready is always high, so the write lands at the access edge
  assign wr_en   = PSEL_IN & PENABLE_IN & PWRITE_IN & PSTRB_IN[0];

  always @* begin
    case (PADDR_IN)
      `SIXP_OFF_DIR,
      `SIXP_OFF_DATA,
      `SIXP_OFF_SERIAL,
      `SIXP_OFF_STBY: addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  end

  // standby control is a software-visible register so both standby kinds are testable
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stby_reg <= 2'b00;
    end else if (wr_en && PADDR_IN == `SIXP_OFF_STBY) begin
      stby_reg <= PWDATA_IN[1:0];
    end
  end

  // hardware standby forces reset values; software standby just holds [RULE6]
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      data_reg <= `SIXP_RESET_VAL; // [RULE5]
      dir_reg  <= `SIXP_RESET_VAL; // [RULE17]
    end else if (hw_stby) begin
      data_reg <= `SIXP_RESET_VAL; // [RULE5]
      dir_reg  <= `SIXP_RESET_VAL; // [RULE17]
    end else if (wr_en) begin
      if (PADDR_IN == `SIXP_OFF_DATA) begin
        data_reg <= (PWDATA_IN[7:0] & `SIXP_PIN_MASK) | `SIXP_FIXED_MASK; // [RULE1] [RULE4]
      end
      if (PADDR_IN == `SIXP_OFF_DIR) begin
        dir_reg <= (PWDATA_IN[7:0] & `SIXP_PIN_MASK) | `SIXP_FIXED_MASK;
      end
    end
  end

  // serial channel mode/control bits that steer the pin functions
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      serial_reg <= 13'h0000;
    end else if (wr_en && PADDR_IN == `SIXP_OFF_SERIAL) begin
      serial_reg <= PWDATA_IN[12:0] & `SIXP_SERIAL_MASK;
    end
  end

  assign clk0_in_sel = serial_reg[`SIXP_B_CLOCK_ENABLE_HIGH_0];
  assign clk1_in_sel = serial_reg[`SIXP_B_CLOCK_ENABLE_HIGH_1];
  assign sync0 = serial_reg[`SIXP_B_SYNC_0] | serial_reg[`SIXP_B_CLOCK_ENABLE_LOW_0];
  assign sync1 = serial_reg[`SIXP_B_SYNC_1] | serial_reg[`SIXP_B_CLOCK_ENABLE_LOW_1];

  always @* begin
    psel_fn = 6'h00;
    pout_fn = 6'h00;
    poe_fn  = 6'h00;
    // pin 5: channel one clock
    if (clk1_in_sel) begin
      psel_fn[5] = 1'b1; // [RULE8]
    end else if (sync1) begin
      psel_fn[5] = 1'b1; // [RULE9]
      pout_fn[5] = SCLK1_IN;
      poe_fn[5]  = 1'b1;
    end
    // pin 4: channel zero clock
    if (clk0_in_sel) begin
      psel_fn[4] = 1'b1; // [RULE10]
    end else if (sync0) begin
      psel_fn[4] = 1'b1; // [RULE10]
      pout_fn[4] = SCLK0_IN;
      poe_fn[4]  = 1'b1;
    end
    psel_fn[3] = serial_reg[`SIXP_B_RE_1]; // [RULE11]
    psel_fn[2] = serial_reg[`SIXP_B_SMART_CARD_IFACE_SELECT] | serial_reg[`SIXP_B_RE_0]; // [RULE12]
    psel_fn[1] = serial_reg[`SIXP_B_TE_1]; // [RULE13]
    pout_fn[1] = TXD1_IN;
    poe_fn[1]  = 1'b1;
    psel_fn[0] = serial_reg[`SIXP_B_SMART_CARD_IFACE_SELECT] | serial_reg[`SIXP_B_TE_0]; // [RULE14]
    pout_fn[0] = TXD0_IN;
    // smart-card transmit releases the pin whenever the channel asks [RULE15]
    poe_fn[0]  = serial_reg[`SIXP_B_SMART_CARD_IFACE_SELECT] ? TXD0_DRIVE_IN : 1'b1;
  end

  // pin drivers follow the held registers, so outputs persist in software standby [RULE18]
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
      sixp_pin_cell u_cell (
        .clk_in        (CLK_SYS_IN),
        .resetn_in     (RESETN_IN),
        .pin_in        (PIN_IN[i]),
        .latch_in      (data_reg[i]),
        .dir_in        (dir_reg[i]),
        .periph_sel_in (psel_fn[i]),
        .periph_out_in (pout_fn[i]),
        .periph_oe_in  (poe_fn[i]),
        .pin_out       (PIN_OUT[i]),
        .pin_oe_n_out  (PIN_OE_N_OUT[i]),
        .level_out     (level[i])
      );
      assign port_read[i] = dir_reg[i] ? data_reg[i] : level[i]; // [RULE2] [RULE3]
    end
  endgenerate

  // receivers and interrupt inputs always see the pin level [RULE7]
  assign RXD0_OUT  = level[2];
  assign RXD1_OUT  = level[3];
  assign SCLK0_OUT = level[4];
  assign SCLK1_OUT = level[5];
  assign EXT_INTERRUPT_FOUR_N_OUT = level[4]; // [RULE7]
  assign EXT_INTERRUPT_FIVE_N_OUT = level[5]; // [RULE7]
  assign SERIAL_CTRL_OUT = serial_reg;

  always @* begin
    rdata_next = 32'h00000000;
    case (PADDR_IN)
      `SIXP_OFF_DIR:    rdata_next = {24'h000000, `SIXP_DIR_READ}; // [RULE17]
      `SIXP_OFF_DATA:   rdata_next = {24'h000000, `SIXP_FIXED_MASK | {2'b00, port_read}}; // [RULE4]
      `SIXP_OFF_SERIAL: rdata_next = {19'h00000, serial_reg};
      `SIXP_OFF_STBY:   rdata_next = {30'h00000000, stby_reg};
      default:          rdata_next = 32'h00000000;
    endcase
  end

  // read data captured in setup so it is stable through the access cycle
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_reg  <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg  <= PWRITE_IN ? 32'h00000000 : rdata_next;
      slverr_reg <= ~addr_ok;
    end
  end

  assign PRDATA_OUT  = rdata_reg;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = slverr_reg & PSEL_IN & PENABLE_IN;
endmodule
`default_nettype wire

// [tb/sixp_port_sva.sv]
// checker of pin function selection and register read replies
`timescale 1ns/1ps
`default_nettype none
module sixp_port_sva (
  input wire logic        CLK_SYS_IN,
  input wire logic        RESETN_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic [5:0]  PIN_OUT,
  input wire logic [5:0]  PIN_OE_N_OUT,
  input wire logic        TXD0_IN,
  input wire logic        TXD0_DRIVE_IN,
  input wire logic        TXD1_IN,
  input wire logic        SCLK1_IN,
  input wire logic [12:0] SERIAL_CTRL_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  wire [12:0] c = SERIAL_CTRL_OUT;
  wire [5:0]  oe_n = PIN_OE_N_OUT;
  // setup then access of a read
  sequence rd_acc(a);
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == a ##1 PENABLE_IN;
  endsequence
  dir_read_a: assert property (rd_acc(12'h000) |-> PRDATA_OUT[7:0] == 8'hff)
    else $error("direction read not all ones");
  data_fixed_a: assert property (rd_acc(12'h004) |-> PRDATA_OUT[7:6] == 2'b11)
    else $error("data bits seven and six not one");
  tx1_drive_a: assert property (c[12] |-> !oe_n[1] && PIN_OUT[1] == TXD1_IN)
    else $error("pin one not driving transmit data");
  tx0_drive_a: assert property (c[4] && !c[5] |-> !oe_n[0] && PIN_OUT[0] == TXD0_IN)
    else $error("pin zero not driving transmit data");
  card_tx_a: assert property (c[5] |-> oe_n[0] == !TXD0_DRIVE_IN)
    else $error("smart card drive state wrong");
  clk1_in_a: assert property (c[9] |-> oe_n[5])
    else $error("pin five driven as clock input");
  clk1_out_a: assert property (!c[9] && (c[10] || c[8]) |-> !oe_n[5] && PIN_OUT[5] == SCLK1_IN)
    else $error("pin five not clock output");
  rx0_in_a: assert property (c[5] || c[3] |-> oe_n[2])
    else $error("pin two driven as receive input");
endmodule
bind sixp_port sixp_port_sva u_sva (.*);
`default_nettype wire

// [tb/sixp_far_model.sv]
// external side of the pins: an outside driver resolved against the port
`timescale 1ns/1ps
`default_nettype none
module sixp_far_model (
  input  wire logic [5:0] pin_out_in,
  input  wire logic [5:0] pin_oe_n_in,
  input  wire logic [5:0] ext_in,
  output logic [5:0]      level_out
);
  // the outside driver yields wherever the port drives, avoiding contention
  assign level_out = (pin_oe_n_in & ext_in) | (~pin_oe_n_in & pin_out_in);
endmodule
`default_nettype wire

// [tb/sixp_bench.sv]
// testbench of the six-bit port: register access and pin function table
`timescale 1ns/1ps
`default_nettype none
module six_bit_port_with_serial_mux_bench;
  logic        clk, rstn, psel, pen, pwr, drv, perr, prdy, err;
  logic        rx0, rx1, sc0, sc1, ext_interrupt_four, ext_interrupt_five;
  logic [11:0] paddr;
  logic [12:0] sctl;
  logic [31:0] pwd, prd, rdata;
  logic [5:0]  ext, lvl, pout, oen;
  int          err_count, checks_done, cyc;
  // po, oe_n, drive bit 13, serial control code
  logic [31:0] tab [12] = '{32'h02001000, 32'h00200200, 32'h20000400, 32'h20000100,
    32'h00100002, 32'h10000001, 32'h10000004, 32'h00080800, 32'h00040008,
    32'h01000010, 32'h00050020, 32'h01042020};
  sixp_port uut (.CLK_SYS_IN(clk), .RESETN_IN(rstn), .PADDR_IN(paddr), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwd), .PSTRB_IN(4'hf),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .PIN_IN(lvl),
    .PIN_OUT(pout), .PIN_OE_N_OUT(oen), .TXD0_IN(1'b1), .TXD0_DRIVE_IN(drv),
    .TXD1_IN(1'b1), .SCLK0_IN(1'b1), .SCLK1_IN(1'b1), .RXD0_OUT(rx0), .RXD1_OUT(rx1),
    .SCLK0_OUT(sc0), .SCLK1_OUT(sc1), .EXT_INTERRUPT_FOUR_N_OUT(ext_interrupt_four),
    .EXT_INTERRUPT_FIVE_N_OUT(ext_interrupt_five), .SERIAL_CTRL_OUT(sctl));
  sixp_far_model far (.pin_out_in(pout), .pin_oe_n_in(oen), .ext_in(ext), .level_out(lvl));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a stuck handshake is cut short here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    paddr <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdata = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdata, e);
  endtask
  task pins(input logic [5:0] o, input logic [5:0] p);
    #1;
    chk({26'h0, oen}, {26'h0, o});
    chk({26'h0, pout & ~oen}, {26'h0, p});
  endtask
  initial begin
    {rstn, psel, pen, pwr, drv, paddr, pwd, err_count, checks_done, cyc} = '0;
    ext = 6'h15;
    repeat (3) @(posedge clk);
    rstn <= 1;
    // pin levels need two edges through the synchroniser before a read
    repeat (2) @(posedge clk);
    rd(12'h004, 32'hd5);
    chk({26'h0, sc1, sc0, rx1, rx0, ext_interrupt_five, ext_interrupt_four}, 32'h15);
    rd(12'h000, 32'hff);
    pins(6'h3f, 6'h00);
    rd(12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // bits seven and six written as zero
    apb(12'h004, 1'b1, 32'h2a);
    apb(12'h000, 1'b1, 32'h3f);
    rd(12'h004, 32'hea);
    pins(6'h00, 6'h2a);
    apb(12'h00c, 1'b1, 32'h2);
    rd(12'h004, 32'hea);
    pins(6'h00, 6'h2a);
    apb(12'h00c, 1'b1, 32'h1);
    // hardware standby forces the registers one edge after the bit lands
    @(posedge clk);
    pins(6'h3f, 6'h00);
    apb(12'h004, 1'b1, 32'h3f);
    apb(12'h00c, 1'b1, 32'h0);
    apb(12'h000, 1'b1, 32'h3f);
    rd(12'h004, 32'hc0);
    for (int i = 0; i < 12; i++) begin
      drv <= tab[i][13];
      apb(12'h008, 1'b1, {19'h0, tab[i][12:0]});
      pins(tab[i][21:16], tab[i][29:24]);
    end
    test_done();
  end
endmodule
`default_nettype wire
